// ===== design/serial_mem_pkg.sv
package serial_mem_pkg;

  // ==========================================================
  // Byte and address layout
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_HI_W = 6;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 14'h0001;

  // ==========================================================
  // Slave address fields
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_SEL_MSB = 3;
  localparam int DEV_SEL_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int DEV_SEL_W = 3;

  // ==========================================================
  // High-speed master code, upper five bits
  localparam logic [4:0] MASTER_CODE = 5'h01;
  localparam int MCODE_MSB = 7;
  localparam int MCODE_LSB = 3;

  // ==========================================================
  // Buffering and timing
  localparam int WR_FIFO_DEPTH = 8;
  localparam int CORE_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;

  // ==========================================================
  // Carriers and states
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_wr_type;

  localparam int MEM_WR_W = ADDR_W + DATA_W;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_DEVADDR = 8'h02,
    ST_ADRHI   = 8'h04,
    ST_ADRLO   = 8'h08,
    ST_WDATA   = 8'h10,
    ST_RDATA   = 8'h20,
    ST_SACK    = 8'h40,
    ST_MACK    = 8'h80
  } link_state_type;

endpackage : serial_mem_pkg

// ===== design/serial_mem_slave.sv
`timescale 1ns/1ps

// ============================================================
// Write buffer
module wr_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] PTR_ONE = {{PW{1'b0}}, 1'b1};
  localparam logic [PW:0] PTR_ZERO = '0;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wptr_q;
  logic [PW:0] rptr_q;
  wire push_w = in_valid && in_ready;
  wire pop_w = out_valid && out_ready;
  wire full_w = (wptr_q[PW] != rptr_q[PW]) &&
                (wptr_q[PW-1:0] == rptr_q[PW-1:0]);
  wire empty_w = (wptr_q == rptr_q);
  assign in_ready = !full_w;
  assign out_valid = !empty_w;
  assign out_data = mem_q[rptr_q[PW-1:0]];
  always_ff @(posedge clk) begin
    if (push_w) begin
      mem_q[wptr_q[PW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_q <= PTR_ZERO;
      rptr_q <= PTR_ZERO;
    end else begin
      wptr_q <= push_w ? wptr_q + PTR_ONE : wptr_q;
      rptr_q <= pop_w ? rptr_q + PTR_ONE : rptr_q;
    end
  end
endmodule : wr_fifo
// ============================================================
// Two-wire memory slave front end
module serial_mem_slave
  import serial_mem_pkg::*;
#(
  parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [DEV_SEL_W-1:0] DEVICE_SELECT_PINS,
  output logic [ADDR_W-1:0] RD_ADDR,
  input wire logic [DATA_W-1:0] RD_DATA,
  output logic WR_VALID,
  input wire logic WR_READY,
  output mem_wr_type WR_WORD,
  output logic HS_MODE
);
  // ==========================================================
  // Synchronisers
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic [DEV_SEL_W-1:0] sel_m_q, sel_s_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      sel_m_q <= '0;
      sel_s_q <= '0;
    end else begin
      scl_m_q <= SCL_IN;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= SDA_IN;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      sel_m_q <= DEVICE_SELECT_PINS;
      sel_s_q <= sel_m_q;
    end
  end
  // ==========================================================
  // Line events
  wire rise_w = scl_s_q && !scl_p_q;
  wire fall_w = !scl_s_q && scl_p_q;
  wire scl_high_w = scl_s_q && scl_p_q;
  wire start_w = scl_high_w && sda_p_q && !sda_s_q;
  wire stop_w = scl_high_w && !sda_p_q && sda_s_q;
  // ==========================================================
  // State
  link_state_type state_q, state_d;
  link_state_type after_q, after_d;
  logic [3:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] shift_q, shift_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [ADDR_HI_W-1:0] addr_hi_q, addr_hi_d;
  logic oe_q, oe_d;
  logic hs_q, hs_d;
  logic push_d;
  logic fifo_ready;
  mem_wr_type push_word;
  // ==========================================================
  // Byte decode
  // device type check
  wire type_ok_w = shift_q[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE;
  wire sel_ok_w = shift_q[DEV_SEL_MSB:DEV_SEL_LSB] == sel_s_q;
  wire match_w = type_ok_w && sel_ok_w;
  wire mcode_w = shift_q[MCODE_MSB:MCODE_LSB] == MASTER_CODE;
  wire rd_req_w = shift_q[RW_BIT];
  wire byte_end_w = fall_w && (cnt_q == BITS_PER_BYTE);
  wire [ADDR_W-1:0] addr_inc_w = addr_q + ADDR_STEP;
  assign push_word.addr = addr_q;
  assign push_word.data = shift_q;
  // ==========================================================
  // Next state
  always_comb begin
    state_d = state_q;
    after_d = after_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    addr_hi_d = addr_hi_q;
    oe_d = oe_q;
    hs_d = hs_q;
    push_d = 1'b0;
    if (start_w) begin
      state_d = ST_DEVADDR;
      cnt_d = CNT_ZERO;
      oe_d = 1'b0;
    end else if (stop_w) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
      hs_d = 1'b0;
    end else begin
      case (state_q)
        ST_DEVADDR, ST_ADRHI, ST_ADRLO, ST_WDATA: begin
          if (rise_w) begin
            shift_d = {shift_q[DATA_W-2:0], sda_s_q};
            cnt_d = cnt_q + CNT_STEP;
          end else if (byte_end_w) begin
            cnt_d = CNT_ZERO;
            state_d = ST_SACK;
            oe_d = 1'b1;
            case (state_q)
              ST_DEVADDR: begin
                if (mcode_w) begin
                  hs_d = 1'b1;
                  state_d = ST_IDLE;
                  oe_d = 1'b0;
                end else if (!match_w) begin
                  state_d = ST_IDLE;
                  oe_d = 1'b0;
                end else begin
                  after_d = rd_req_w ? ST_RDATA : ST_ADRHI;
                end
              end
              ST_ADRHI: begin
                addr_hi_d = shift_q[ADDR_HI_W-1:0];
                after_d = ST_ADRLO;
              end
              ST_ADRLO: begin
                addr_d = {addr_hi_q, shift_q};
                after_d = ST_WDATA;
              end
              default: begin
                // accept byte then ack; full buffer nacks
                if (fifo_ready) begin
                  push_d = 1'b1;
                  addr_d = addr_inc_w;
                  after_d = ST_WDATA;
                end else begin
                  state_d = ST_IDLE;
                  oe_d = 1'b0;
                end
              end
            endcase
          end
        end
        ST_SACK: begin
          if (fall_w) begin
            oe_d = 1'b0;
            cnt_d = CNT_ZERO;
            state_d = after_q;
            if (after_q == ST_RDATA) begin
              shift_d = RD_DATA;
              oe_d = !RD_DATA[DATA_W-1];
            end
          end
        end
        ST_RDATA: begin
          if (rise_w) begin
            cnt_d = cnt_q + CNT_STEP;
          end else if (byte_end_w) begin
            // release for master ack, step address
            oe_d = 1'b0;
            cnt_d = CNT_ZERO;
            addr_d = addr_inc_w;
            state_d = ST_MACK;
          end else if (fall_w) begin
            shift_d = {shift_q[DATA_W-2:0], 1'b0};
            oe_d = !shift_q[DATA_W-2];
          end
        end
        ST_MACK: begin
          if (rise_w) begin
            if (sda_s_q) begin
              state_d = ST_IDLE;
            end else begin
              cnt_d = CNT_ONE;
            end
          end else if (fall_w && cnt_q == CNT_ONE) begin
            shift_d = RD_DATA;
            oe_d = !RD_DATA[DATA_W-1];
            cnt_d = CNT_ZERO;
            state_d = ST_RDATA;
          end
        end
        default: begin
        end
      endcase
    end
  end
  // ==========================================================
  // Registers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      shift_q <= '0;
      addr_q <= ADDR_RESET;
      addr_hi_q <= '0;
      oe_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      state_q <= state_d;
      after_q <= after_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      addr_hi_q <= addr_hi_d;
      oe_q <= oe_d;
      hs_q <= hs_d;
    end
  end
  // ==========================================================
  // Write buffer toward the array
  logic [MEM_WR_W-1:0] fifo_out;
  wr_fifo #(
    .WIDTH(MEM_WR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .in_valid(push_d),
    .in_ready(fifo_ready),
    .in_data(push_word),
    .out_valid(WR_VALID),
    .out_ready(WR_READY),
    .out_data(fifo_out)
  );
  assign WR_WORD = mem_wr_type'(fifo_out);
  // ==========================================================
  // Pin outputs
  // open drain, low only
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_q;
  assign RD_ADDR = addr_q;
  assign HS_MODE = hs_q;
  // ==========================================================
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence byte_end_s;
    fall_w && (cnt_q == BITS_PER_BYTE);
  endsequence
  sequence addr_byte_s;
    (state_q == ST_DEVADDR) ##0 byte_end_s;
  endsequence
  open_drain_a: assert property (
    SDA_OE |-> !SDA_OUT
  ) else $error("SDA driven high");
  start_restart_a: assert property (
    start_w |=> (state_q == ST_DEVADDR) && !SDA_OE && (cnt_q == CNT_ZERO)
  ) else $error("START did not restart");
  stop_abort_a: assert property (
    stop_w |=> (state_q == ST_IDLE) && !SDA_OE && !HS_MODE
  ) else $error("STOP did not abort");
  addr_reject_a: assert property (
    addr_byte_s ##0 (!match_w && !start_w && !stop_w)
      |=> (state_q == ST_IDLE) && !SDA_OE
  ) else $error("Foreign address answered");
  addr_accept_a: assert property (
    addr_byte_s ##0 (match_w && !mcode_w && !start_w && !stop_w)
      |=> (state_q == ST_SACK) && SDA_OE
  ) else $error("Own address not acknowledged");
  hs_entry_a: assert property (
    addr_byte_s ##0 (mcode_w && !start_w && !stop_w) |=> HS_MODE && !SDA_OE
  ) else $error("Master code not handled");
  write_step_a: assert property (
    push_d |=> addr_q == ($past(addr_q) + ADDR_STEP)
  ) else $error("Address did not step");
  addr_load_a: assert property (
    (state_q == ST_ADRLO) ##0 byte_end_s ##0 (!start_w && !stop_w)
      |=> addr_q == {$past(addr_hi_q), $past(shift_q)}
  ) else $error("Address not latched");
  read_nack_a: assert property (
    (state_q == ST_MACK) && rise_w && sda_s_q && !start_w && !stop_w
      |=> (state_q == ST_IDLE) ##1 !SDA_OE
  ) else $error("Read went on after no-acknowledge");
  edge_change_a: assert property (
    $changed(oe_q) |-> $past(fall_w || start_w || stop_w)
  ) else $error("SDA changed away from SCL fall");
endmodule : serial_mem_slave

// ===== tb/bus_master_model.sv
`timescale 1ns/1ps

// ==========================================================
// Two-wire bus master model
module bus_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic put_bit(input logic b, output logic s);
    tick(2);
    sda_low <= !b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    s = sda;
    scl <= 1'b0;
  endtask : put_bit

  task automatic start;
    tick(2);
    sda_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : start

  task automatic stop;
    tick(2);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask : stop

  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask : wr

  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(!ack, s);
  endtask : rd
endmodule : bus_master_model

// ===== tb/testbench.sv
`timescale 1ns/1ps

// ==========================================================
// Bench top
module testbench
  import serial_mem_pkg::*;
  ;
  localparam logic [2:0] SEL = 3'h5;
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic WR_READY = 1'b1;
  logic SDA_OUT, SDA_OE, WR_VALID, HS_MODE, scl, sda_low, sda_line;
  logic [ADDR_W-1:0] RD_ADDR;
  logic [DATA_W-1:0] mem [0:16383];
  mem_wr_type WR_WORD;
  int error_cnt = 0;
  int comparisons = 0;

  always #20 CORE_CLK = ~CORE_CLK;
  // Wired-and line with pull-up
  assign sda_line = !(sda_low || (SDA_OE && !SDA_OUT));

  // Memory array takes words from the buffer
  always @(posedge CORE_CLK) begin
    if (WR_VALID && WR_READY) begin
      mem[WR_WORD.addr] <= WR_WORD.data;
    end
  end

  serial_mem_slave u_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .DEVICE_SELECT_PINS(SEL), .RD_ADDR(RD_ADDR), .RD_DATA(mem[RD_ADDR]),
    .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_WORD(WR_WORD),
    .HS_MODE(HS_MODE));

  bus_master_model u_master (.clk(CORE_CLK), .sda(sda_line), .scl(scl),
    .sda_low(sda_low));

  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic t_write;
    logic a;
    logic [7:0] q [6] = '{{DEV_TYPE, SEL, 1'b0}, 8'hFF, 8'hFE, 8'hA5,
      8'h3C, 8'h81};
    u_master.start();
    foreach (q[i]) begin
      u_master.wr(q[i], a);
      check(a, 1);
    end
    u_master.stop();
    u_master.tick(6);
    check(mem[14'h3FFE], 8'hA5);
    check(mem[14'h3FFF], 8'h3C);
    check(mem[14'h0000], 8'h81);
    check(RD_ADDR, 14'h0001);
  endtask : t_write

  task automatic t_read;
    logic a;
    logic [7:0] d;
    u_master.start();
    u_master.wr({DEV_TYPE, SEL, 1'b0}, a);
    u_master.wr(8'h3F, a);
    u_master.wr(8'hFF, a);
    u_master.start();
    u_master.wr({DEV_TYPE, SEL, 1'b1}, a);
    check(a, 1);
    u_master.rd(1'b1, d);
    check(d, 8'h3C);
    u_master.rd(1'b0, d);
    check(d, 8'h81);
    u_master.stop();
    check(RD_ADDR, 14'h0001);
  endtask : t_read

  task automatic t_refuse;
    logic a;
    logic [7:0] q [4] = '{{4'hB, SEL, 1'b0}, {DEV_TYPE, SEL ^ 3'h1, 1'b0},
      {DEV_TYPE, SEL ^ 3'h4, 1'b1}, 8'h0F};
    foreach (q[i]) begin
      u_master.start();
      u_master.wr(q[i], a);
      check(a, 0);
    end
    check(HS_MODE, 1);
    u_master.start();
    u_master.wr({DEV_TYPE, SEL, 1'b0}, a);
    check(a, 1);
    u_master.stop();
    u_master.tick(2);
    check(HS_MODE, 0);
  endtask : t_refuse

  task automatic t_fifo;
    logic a;
    WR_READY <= 1'b0;
    u_master.start();
    u_master.wr({DEV_TYPE, SEL, 1'b0}, a);
    u_master.wr(8'h00, a);
    u_master.wr(8'h10, a);
    for (int i = 0; i <= 8; i++) begin
      u_master.wr(8'h40 + 8'(i), a);
      check(a, i < 8);
    end
    check(WR_WORD, {14'h0010, 8'h40});
    u_master.stop();
    WR_READY <= 1'b1;
    u_master.tick(12);
    check(WR_VALID, 0);
    check(mem[14'h0017], 8'h47);
    u_master.start();
    u_master.wr({DEV_TYPE, SEL, 1'b0}, a);
    u_master.wr(8'h00, a);
    u_master.wr(8'h20, a);
    repeat (4) u_master.put_bit(1'b0, a);
    u_master.stop();
    u_master.tick(4);
    check(WR_VALID, 0);
    check({SDA_OE, SDA_OUT}, 0);
  endtask : t_fifo

  initial begin
    repeat (12) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    u_master.tick(3);
    t_write();
    t_read();
    t_refuse();
    t_fifo();
    finish_test();
  end

  initial begin
    repeat (25000) @(posedge CORE_CLK);
    error_cnt++;
    finish_test();
  end
endmodule : testbench
